// ==== bench/sram_host_properties.sv ====
// Pin checks for the static memory host controller.
// Assumes it is bound to sram_host and sees its ports only.
`timescale 1ns/100ps
module sram_host_properties #(
  parameter int POWER_UP_CYCLES = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // User side
  input wire logic req,
  input wire logic req_write,
  input wire logic ack,
  input wire logic ready,
  // Memory pins
  input wire logic [sram_host_pkg::ADDR_W-1:0] mem_addr,
  input wire logic chip_select_primary_n,
  input wire logic chip_select_secondary,
  input wire logic drive_enable_n,
  input wire logic store_strobe_n,
  input wire logic [sram_host_pkg::DATA_W-1:0] mem_data_out,
  input wire logic [sram_host_pkg::DATA_W-1:0] mem_data_oe_n
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  wire sel = !chip_select_primary_n && chip_select_secondary;
  wire taken = req && ready;

  select_pair_a: assert property (
    chip_select_primary_n == !chip_select_secondary)
    else $error("chip selects disagree");
  read_strobe_a: assert property (
    !drive_enable_n |-> store_strobe_n && sel)
    else $error("strobe low during read");
  strobe_width_a: assert property (
    $fell(store_strobe_n) |=> store_strobe_n && sel)
    else $error("strobe width wrong");
  store_hold_a: assert property (
    $rose(store_strobe_n)
    |-> sel && $stable(mem_addr) && $stable(mem_data_out))
    else $error("write end not held");
  drive_select_a: assert property (
    mem_data_oe_n != '1 |-> sel && drive_enable_n)
    else $error("data driven outside write");
  read_ack_a: assert property (taken && !req_write |-> ##5 ack)
    else $error("read ack late");
  write_ack_a: assert property (taken && req_write |-> ##3 ack)
    else $error("write ack late");
  power_wait_a: assert property ($rose(rstn) |-> !ready [*3])
    else $error("ready during power wait");
  read_addr_a: assert property (
    !drive_enable_n && !$past(drive_enable_n) |-> $stable(mem_addr))
    else $error("address moved in read");
  cover property (taken && !req_write);
  cover property (taken && req_write);
  cover property ($rose(store_strobe_n) && mem_data_oe_n[15:8] == 8'hFF);
endmodule : sram_host_properties

bind sram_host sram_host_properties #(
  .POWER_UP_CYCLES(POWER_UP_CYCLES)
) sram_host_properties_inst (.*);

// ==== bench/sram_host_tb.sv ====
// Self-checking bench for sram_host against the memory model.
// Assumes a 50 MHz core clock and a shortened power-up wait of 4.
`timescale 1ns/100ps
module sram_host_tb;
  logic core_clk, rstn, req, req_write, ack, ready;
  logic [19:0] req_addr, mem_addr;
  logic [15:0] req_wdata, rdata, din, dout, oe_n, q;
  logic [1:0] req_lanes;
  logic cp_n, cs, de_n, st_n, ll_n, ul_n;
  int err_total = 0;
  int samples_checked = 0;

  sram_host #(.POWER_UP_CYCLES(4)) sram_host_inst (.core_clk(core_clk),
    .rstn(rstn), .req(req), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_lanes(req_lanes), .ack(ack),
    .rdata(rdata), .ready(ready), .mem_addr(mem_addr),
    .chip_select_primary_n(cp_n), .chip_select_secondary(cs),
    .drive_enable_n(de_n), .store_strobe_n(st_n),
    .lower_lane_select_n(ll_n), .upper_lane_select_n(ul_n),
    .mem_data_in(din), .mem_data_out(dout), .mem_data_oe_n(oe_n));
  sram_model sram_model_inst (.mem_addr(mem_addr),
    .chip_select_primary_n(cp_n), .chip_select_secondary(cs),
    .drive_enable_n(de_n), .store_strobe_n(st_n),
    .lower_lane_select_n(ll_n), .upper_lane_select_n(ul_n),
    .mem_data_out(dout), .mem_data_oe_n(oe_n), .mem_data_in(din));

  initial
  begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One request held until ack; bounded so a hang is reported
  task xfer(input logic w, input logic [19:0] a, input logic [15:0] d,
    input logic [1:0] l);
    int n;
    n = 0;
    @(negedge core_clk);
    req = 1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    req_lanes = l;
    do
    begin
      @(posedge core_clk);
      #1 n++;
    end while (ack !== 1'b1 && n < 100);
    q = rdata;
    chk({15'h0000, ack}, 16'h0001);
    @(negedge core_clk);
    req = 0;
  endtask : xfer

  task test_done;
    $display("Checks %0d, errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  task t_power;
    @(negedge core_clk);
    chk({cp_n, cs, st_n, de_n, ll_n, ul_n, ready, ack}, 16'h00BC);
    chk(oe_n, 16'hFFFF);
    rstn = 1;
    req = 1;
    repeat (2) @(negedge core_clk);
    chk({15'h0000, ready | ack}, 16'h0000);
    req = 1'b0;
  endtask : t_power

  task t_lanes;
    xfer(1'b1, 20'h00012, 16'hA5C3, 2'h3);
    xfer(1'b0, 20'h00012, 16'h0000, 2'h3);
    chk(q, 16'hA5C3);
    xfer(1'b1, 20'h00012, 16'h117E, 2'h1);
    xfer(1'b0, 20'h00012, 16'h0000, 2'h2);
    chk(q, 16'hA500);
    xfer(1'b0, 20'h00012, 16'h0000, 2'h1);
    chk(q, 16'h007E);
    xfer(1'b1, 20'h00012, 16'hFFFF, 2'h0);
    xfer(1'b0, 20'h00012, 16'h0000, 2'h3);
    chk(q, 16'hA57E);
  endtask : t_lanes

  // Back-to-back traffic, including the top address
  task t_burst;
    for (int i = 0; i < 4; i++)
      xfer(1'b1, 20'(20'hFFFFC + i), 16'(16'h3C00 + i), 2'h3);
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b0, 20'(20'hFFFFC + i), 16'h0000, 2'h3);
      chk(q, 16'(16'h3C00 + i));
    end
  endtask : t_burst

  initial
  begin
    rstn = 0;
    req = 0;
    req_write = 0;
    req_addr = 20'h00000;
    req_wdata = 16'h0000;
    req_lanes = 2'h0;
    repeat (8) @(negedge core_clk);
    t_power();
    t_lanes();
    t_burst();
    test_done();
  end

  // Whole run is well under a thousand cycles
  initial
  begin
    #100000;
    err_total++;
    test_done();
  end
endmodule : sram_host_tb

// ==== bench/sram_model.sv ====
// Behavioural 16-bit static memory, 256 words, address bits above 7 unused.
// Assumes the controller's data bus is split into out, per-bit enable, in.
`timescale 1ns/100ps
module sram_model (
  // Pins from the controller
  input wire logic [sram_host_pkg::ADDR_W-1:0] mem_addr,
  input wire logic chip_select_primary_n,
  input wire logic chip_select_secondary,
  input wire logic drive_enable_n,
  input wire logic store_strobe_n,
  input wire logic lower_lane_select_n,
  input wire logic upper_lane_select_n,
  input wire logic [15:0] mem_data_out,
  input wire logic [15:0] mem_data_oe_n,
  // Data back to the controller
  output logic [15:0] mem_data_in
);
  logic [15:0] mem [256];
  logic [15:0] wd;
  logic sel, rd, lo, hi;
  logic [15:0] q;
  initial for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
  assign sel = !chip_select_primary_n && chip_select_secondary;
  // Undriven bits come back inverted, never as a clean copy
  assign wd = mem_data_out ^ mem_data_oe_n;
  always @(posedge store_strobe_n)
    if (sel)
    begin
      if (!lower_lane_select_n) mem[mem_addr[7:0]][7:0] = wd[7:0];
      if (!upper_lane_select_n) mem[mem_addr[7:0]][15:8] = wd[15:8];
    end
  assign rd = sel && store_strobe_n && !drive_enable_n;
  assign lo = rd && !lower_lane_select_n;
  assign hi = rd && !upper_lane_select_n;
  assign q = mem[mem_addr[7:0]];
  // Floated lanes show the inverse of the stored byte
  assign #5 mem_data_in = {hi ? q[15:8] : ~q[15:8],
    lo ? q[7:0] : ~q[7:0]};
endmodule : sram_model

// ==== core/sram_host.sv ====
// Host controller driving an asynchronous 16-bit static memory by its pins.
// Assumes the user keeps req held until ack; read data returns unclocked.
// Summary of operation
// R1: Select means primary low, secondary high.
// R2: Reads drive only lanes whose select is low.
// R3: Writes use lane selects; drive enable ignored.
// R4: Selected, strobe and drive enable high: floats.
// R5: Write ends at first deasserting control edge.
// R6: Read data valid 10 ns after address.
// R7: Old data held 3 ns after address change.
// R8: Drive enable access and float within 5 ns.
// R9: Lane select access within 5 ns.
// R10: Lane float within 6 ns of deselect.
// R11: Address stable 7 ns before write end.
// R12: Lane selects, strobe low 7 ns before end.
// R13: Write data 5 ns setup, 0 ns hold.
// R14: Strobe-ended cycle covers float plus setup.
// R15: Wait 100 us after supply before access.
// R16: Simultaneous deselect and strobe end: stays floating.
// R17: Address valid no later than select.
// R18: Write strobe high during every read.
// R19: Lane floats when drive enable or select high.
// R20: Space cycles by minimum cycle times.
`timescale 1ns/100ps
module sram_host #(
  parameter int POWER_UP_CYCLES = sram_host_pkg::POWER_UP_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // User request side
  input wire logic req,
  input wire logic req_write,
  input wire logic [sram_host_pkg::ADDR_W-1:0] req_addr,
  input wire logic [sram_host_pkg::DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_lanes,
  output logic ack,
  output logic [sram_host_pkg::DATA_W-1:0] rdata,
  output logic ready,
  // Memory pins
  output logic [sram_host_pkg::ADDR_W-1:0] mem_addr,
  output logic chip_select_primary_n,
  output logic chip_select_secondary,
  output logic drive_enable_n,
  output logic store_strobe_n,
  output logic lower_lane_select_n,
  output logic upper_lane_select_n,
  input wire logic [sram_host_pkg::DATA_W-1:0] mem_data_in,
  output logic [sram_host_pkg::DATA_W-1:0] mem_data_out,
  output logic [sram_host_pkg::DATA_W-1:0] mem_data_oe_n
);

  localparam logic [sram_host_pkg::CNT_W-1:0] READ_WAIT =
    sram_host_pkg::CNT_W'(sram_host_pkg::READ_WAIT_CYC
    + sram_host_pkg::SYNC_STAGES);
  localparam logic [sram_host_pkg::CNT_W-1:0] STROBE =
    sram_host_pkg::CNT_W'(sram_host_pkg::STROBE_CYC);
  localparam logic [sram_host_pkg::CNT_W-1:0] FLOAT =
    sram_host_pkg::CNT_W'(sram_host_pkg::FLOAT_CYC);
  localparam logic [sram_host_pkg::CNT_W-1:0] CYCLE_MIN =
    sram_host_pkg::CNT_W'(sram_host_pkg::CYCLE_MIN_CYC);
  localparam logic [31:0] POWER_LIMIT = 32'(POWER_UP_CYCLES);

  sram_host_pkg::host_state_t state_r;
  sram_host_pkg::host_state_t state_nxt;
  logic [sram_host_pkg::CNT_W-1:0] cnt_r;
  logic [31:0] power_cnt_r;
  logic [sram_host_pkg::CNT_W-1:0] gap_r;
  logic [sram_host_pkg::DATA_W-1:0] sync1_r;
  logic [sram_host_pkg::DATA_W-1:0] sync2_r;
  logic [1:0] lanes_r;
  logic wr_r;
  logic start;
  logic [1:0] lanes_now;

  // Pins are active in the read wait and in both write phases
  function automatic logic mem_active(
    input sram_host_pkg::host_state_t s
  );
    return s == sram_host_pkg::ST_READ || s == sram_host_pkg::ST_STROBE
      || s == sram_host_pkg::ST_HOLD;
  endfunction : mem_active

  assign ready = (state_r == sram_host_pkg::ST_IDLE)
    && (gap_r >= CYCLE_MIN); // R20
  assign start = ready && req;
  // New lanes apply at the launch edge, else the first cycle is stale
  assign lanes_now = start ? req_lanes : lanes_r;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      sram_host_pkg::ST_POWER:
        if (power_cnt_r >= POWER_LIMIT)
          state_nxt = sram_host_pkg::ST_IDLE; // R15
      sram_host_pkg::ST_IDLE:
        if (start)
          state_nxt = req_write ? sram_host_pkg::ST_STROBE
            : sram_host_pkg::ST_READ;
      sram_host_pkg::ST_READ:
        if (cnt_r >= READ_WAIT)
          state_nxt = sram_host_pkg::ST_CAPTURE; // R6
      sram_host_pkg::ST_CAPTURE:
        state_nxt = sram_host_pkg::ST_FLOAT;
      sram_host_pkg::ST_STROBE:
        if (cnt_r >= STROBE)
          state_nxt = sram_host_pkg::ST_HOLD; // R12 R14
      sram_host_pkg::ST_HOLD:
        state_nxt = sram_host_pkg::ST_FLOAT;
      sram_host_pkg::ST_FLOAT:
        if (cnt_r >= FLOAT)
          state_nxt = sram_host_pkg::ST_IDLE; // R8
      // Unused code falls back to the power-up wait
      default:
        state_nxt = sram_host_pkg::ST_POWER;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      state_r <= sram_host_pkg::ST_POWER;
    else
      state_r <= state_nxt;
  end

  // Phase counter restarts on every state change
  always_ff @(posedge core_clk)
  begin
    if (!rstn || state_nxt != state_r)
      cnt_r <= sram_host_pkg::CNT_W'(1'b1);
    else if (cnt_r != '1)
      cnt_r <= cnt_r + 1'b1;
  end

  // Restarts on controller reset, since supply state is unknown to it
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      power_cnt_r <= '0;
    else if (state_r == sram_host_pkg::ST_POWER)
      power_cnt_r <= power_cnt_r + 1'b1; // R15
  end

  // Cycles since last address launch
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      gap_r <= CYCLE_MIN;
    else if (start)
      gap_r <= sram_host_pkg::CNT_W'(1'b1); // R20
    else if (gap_r != '1)
      gap_r <= gap_r + 1'b1;
  end

  // Address, data and lanes launched together with the request
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      mem_addr <= '0;
      mem_data_out <= '0;
      lanes_r <= 2'h0;
      wr_r <= 1'b0;
    end
    else if (start)
    begin
      mem_addr <= req_addr; // R11 R17
      mem_data_out <= req_wdata; // R13
      lanes_r <= req_lanes;
      wr_r <= req_write;
    end
  end

  // Control pins from flops; address and select change on the same launch edge
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      chip_select_primary_n <= 1'b1;
      chip_select_secondary <= 1'b0;
      drive_enable_n <= 1'b1;
      store_strobe_n <= 1'b1;
      lower_lane_select_n <= 1'b1;
      upper_lane_select_n <= 1'b1;
    end
    else
    begin
      chip_select_primary_n <= !mem_active(state_nxt); // R1
      chip_select_secondary <= mem_active(state_nxt); // R1
      drive_enable_n <= state_nxt != sram_host_pkg::ST_READ; // R2 R19
      // Strobe only in write; high throughout reads
      store_strobe_n <= state_nxt != sram_host_pkg::ST_STROBE; // R5 R18
      lower_lane_select_n <= !(lanes_now[0] && mem_active(state_nxt)); // R2 R3
      upper_lane_select_n <= !(lanes_now[1] && mem_active(state_nxt)); // R2 R3
    end
  end

  // Drive data through strobe and one hold cycle
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      mem_data_oe_n <= '1;
    else if (state_nxt == sram_host_pkg::ST_STROBE
      || state_nxt == sram_host_pkg::ST_HOLD)
      mem_data_oe_n <= {{sram_host_pkg::LANE_W{!lanes_now[1]}},
        {sram_host_pkg::LANE_W{!lanes_now[0]}}}; // R13
    else
      mem_data_oe_n <= '1;
  end

  // Read data crosses from the pins through two flops
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= mem_data_in;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      rdata <= '0;
    else if (state_r == sram_host_pkg::ST_CAPTURE)
      rdata <= {lanes_r[1] ? sync2_r[sram_host_pkg::DATA_W-1:
        sram_host_pkg::LANE_W] : sram_host_pkg::LANE_W'(0),
        lanes_r[0] ? sync2_r[sram_host_pkg::LANE_W-1:0]
        : sram_host_pkg::LANE_W'(0)}; // R2
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      ack <= 1'b0;
    else
      ack <= state_r == sram_host_pkg::ST_CAPTURE
        || (state_r == sram_host_pkg::ST_HOLD && wr_r);
  end

endmodule : sram_host

// ==== core/sram_host_pkg.sv ====
// Constants for the asynchronous static memory host controller.
// Assumes a single 50 MHz core clock; all pin timing is counted in cycles.
package sram_host_pkg;

  localparam int CLK_PERIOD_PS = 20000;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;

  // Pin timing figures, in picoseconds (printed figure times 1000)
  localparam int ADDR_ACCESS_DELAY_PS = 10 * 1000;
  localparam int DRIVE_ENABLE_ACCESS_DELAY_PS = 5 * 1000;
  localparam int LANE_SELECT_ACCESS_DELAY_PS = 5 * 1000;
  localparam int DRIVE_ENABLE_FLOAT_DELAY_PS = 5 * 1000;
  localparam int LANE_SELECT_FLOAT_DELAY_PS = 6 * 1000;
  localparam int STROBE_LOW_FLOAT_DELAY_PS = 5 * 1000;
  localparam int ADDR_SETUP_TO_STORE_END_PS = 7 * 1000;
  localparam int LANE_SELECT_TO_STORE_END_PS = 7 * 1000;
  localparam int STORE_STROBE_WIDTH_PS = 7 * 1000;
  localparam int WDATA_SETUP_TO_STORE_END_PS = 5 * 1000;
  localparam int READ_CYCLE_PS = 10 * 1000;
  localparam int WRITE_CYCLE_PS = 10 * 1000;
  // Supply to first access, in microseconds
  localparam int SUPPLY_TO_FIRST_ACCESS_US = 100;

  function automatic int ceil_cycles(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : ceil_cycles

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : max2

  // Read: the longest of address, drive enable and lane access, plus two
  // cycles for the input synchroniser on the returning data.
  localparam int READ_WAIT_CYC = ceil_cycles(max2(ADDR_ACCESS_DELAY_PS,
    max2(DRIVE_ENABLE_ACCESS_DELAY_PS, LANE_SELECT_ACCESS_DELAY_PS)));
  localparam int SYNC_STAGES = 2;
  // Strobe low long enough for width, lane select, address and data setup
  // and for the strobe-low float delay plus data setup.
  localparam int STROBE_CYC = ceil_cycles(max2(max2(STORE_STROBE_WIDTH_PS,
    LANE_SELECT_TO_STORE_END_PS), max2(ADDR_SETUP_TO_STORE_END_PS,
    STROBE_LOW_FLOAT_DELAY_PS + WDATA_SETUP_TO_STORE_END_PS)));
  localparam int FLOAT_CYC = ceil_cycles(max2(DRIVE_ENABLE_FLOAT_DELAY_PS,
    LANE_SELECT_FLOAT_DELAY_PS));
  localparam int CYCLE_MIN_CYC = ceil_cycles(max2(READ_CYCLE_PS,
    WRITE_CYCLE_PS));
  localparam int POWER_UP_CYC = SUPPLY_TO_FIRST_ACCESS_US * 1000 * 1000
    / CLK_PERIOD_PS;
  localparam int CNT_W = 16;

  typedef enum logic [2:0] {
    ST_POWER,
    ST_IDLE,
    ST_READ,
    ST_CAPTURE,
    ST_STROBE,
    ST_HOLD,
    ST_FLOAT
  } host_state_t;

endpackage : sram_host_pkg
